// File: eipl_pkg.sv
package eipl_pkg;

  // ****************************************
  // Register map: word index, byte address is four times the index
  // ****************************************
  localparam logic [7:0] ADDR_CONFIG_TWO = 8'h1E;
  localparam logic [7:0] ADDR_STATUS_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_BREAK_FLAG_CONTROL = 8'h24;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h28;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h2C;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CFG_PULLUP_DIS_BIT = 0;
  localparam int CFG_FUNC_EN_BIT = 1;
  localparam int SC_MODE_BIT = 0;
  localparam int SC_MASK_BIT = 1;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_PEND_BIT = 3;
  localparam int BFC_CLEAR_EN_BIT = 7;
  localparam int EVT_LATCH_BIT = 0;
  localparam int EVT_ACK_BIT = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CONFIG_TWO_RST = 8'h00;
  localparam logic EVT_MASK_RST = 1'b0;

  // ****************************************
  // Carried types
  // ****************************************
  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
  } eipl_ahb_req_s;

  typedef struct packed {
    logic vector_fetch;
    logic global_mask;
    logic break_state;
    logic wait_state;
    logic stop_state;
  } eipl_cpu_s;

endpackage : eipl_pkg

// File: eipl_top.sv
`timescale 1ns/1ps
// Behaviour
// R1: Interrupt function active only when enable set
// R2: Latch holds until acknowledge or reset
// R3: Vector fetch acknowledges and clears latch
// R4: Ack bit write-one clears; reads zero
// R5: Reset clears latch and trigger mode
// R6: Mask bit withholds request from priority
// R7: CPU global mask also blocks request
// R8: Level mode: clear needs pin high plus ack
// R9: Edge after ack latches new request
// R10: Edge mode: ack clears immediately
// R11: Pending flag readable, independent of mask
// R12: Branch pin test sees one when disabled
// R13: Port A bit two reads zero when enabled
// R14: Pullup on unless pullup-disable set
// R15: Active in wait/stop; request wakes
// R16: Break with clear-enable: ack clears, stays
// R17: Break without clear-enable: status unchanged
// R18: Software masks inside level-mode service routine
// R19: Pin synchronised, falling edge by compare
module eipl_top
  import eipl_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire eipl_pkg::eipl_ahb_req_s AHB_REQ,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Interrupt pin, active low
  input wire logic EXT_INT_N,
  // CPU side
  input wire eipl_pkg::eipl_cpu_s CPU,
  input wire logic PORT_A_BIT_TWO_IN,
  output logic EXT_INT_REQ,
  output logic WAKEUP,
  output logic BRANCH_PIN_HIGH,
  output logic PORT_A_BIT_TWO_RD,
  output logic PULLUP_EN,
  // Event interrupt
  output logic IRQ
);
  import eipl_pkg::*;

  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  logic pin_s1_r, pin_s2_r, pin_prev_r;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      pin_s1_r <= EXT_INT_N; // R19
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  logic [7:0] config_two_r;
  logic mode_r, mask_r, clear_en_r, latch_r;
  logic [1:0] evt_status_r;
  logic evt_mask_r;
  logic func_en;
  assign func_en = config_two_r[CFG_FUNC_EN_BIT];
  logic fall_edge;
  assign fall_edge = func_en && pin_prev_r && !pin_s2_r; // R19

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic acc;
  assign acc = AHB_REQ.hsel && AHB_REQ.hready && AHB_REQ.htrans[1];
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc && AHB_REQ.hwrite;
      wr_addr_r <= AHB_REQ.haddr[9:2];
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr_pend_r && (wr_addr_r == a);
  endfunction : wr_hit

  logic ack_write;
  assign ack_write = wr_hit(ADDR_STATUS_CONTROL) && HWDATA[SC_ACK_BIT];
  // Break without clear-enable blocks software clears
  logic sw_ack;
  assign sw_ack = ack_write && (!CPU.break_state || clear_en_r); // R16 R17
  logic any_ack;
  assign any_ack = sw_ack || (CPU.vector_fetch && func_en); // R3

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      config_two_r <= CONFIG_TWO_RST;
      mode_r <= 1'b0; // R5
      mask_r <= 1'b0;
      clear_en_r <= 1'b0;
      evt_mask_r <= EVT_MASK_RST;
    end else begin
      if (wr_hit(ADDR_CONFIG_TWO))
        config_two_r <= HWDATA[7:0];
      if (wr_hit(ADDR_STATUS_CONTROL)) begin
        mode_r <= HWDATA[SC_MODE_BIT];
        mask_r <= HWDATA[SC_MASK_BIT];
      end
      if (wr_hit(ADDR_BREAK_FLAG_CONTROL))
        clear_en_r <= HWDATA[BFC_CLEAR_EN_BIT];
      if (wr_hit(ADDR_EVT_MASK))
        evt_mask_r <= HWDATA[EVT_LATCH_BIT];
    end
  end

  // ****************************************
  // Request latch
  // ****************************************
  logic level_hold;
  assign level_hold = mode_r && func_en && !pin_s2_r; // R8
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      latch_r <= 1'b0; // R5
    end else if (fall_edge) begin
      latch_r <= 1'b1; // R9
    end else if (any_ack) begin
      latch_r <= 1'b0; // R2 R4 R10
    end
  end

  logic pending;
  assign pending = latch_r || level_hold; // R8 R11

  // ****************************************
  // Event status (write one to clear)
  // ****************************************
  logic [1:0] evt_set;
  assign evt_set = {any_ack && pending, fall_edge};
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      evt_status_r <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (evt_set[i])
          evt_status_r[i] <= 1'b1;
        else if (wr_hit(ADDR_EVT_STATUS) && HWDATA[i])
          evt_status_r[i] <= 1'b0;
      end
    end
  end
  assign IRQ = (evt_status_r[EVT_LATCH_BIT] && evt_mask_r) || evt_status_r[EVT_ACK_BIT] && evt_mask_r;

  // ****************************************
  // Read data
  // ****************************************
  logic [7:0] rd_addr_r;
  logic rd_pend_r;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rd_addr_r <= 8'h00;
      rd_pend_r <= 1'b0;
    end else begin
      rd_addr_r <= AHB_REQ.haddr[9:2];
      rd_pend_r <= acc && !AHB_REQ.hwrite;
    end
  end
  always_comb begin
    HRDATA = 32'h0000_0000;
    if (rd_pend_r) begin
      case (rd_addr_r)
        ADDR_CONFIG_TWO: HRDATA[7:0] = config_two_r;
        ADDR_STATUS_CONTROL: begin
          HRDATA[SC_MODE_BIT] = mode_r;
          HRDATA[SC_MASK_BIT] = mask_r;
          HRDATA[SC_ACK_BIT] = 1'b0; // R4
          HRDATA[SC_PEND_BIT] = pending; // R11
        end
        ADDR_BREAK_FLAG_CONTROL: HRDATA[BFC_CLEAR_EN_BIT] = clear_en_r;
        ADDR_EVT_STATUS: HRDATA[1:0] = evt_status_r;
        ADDR_EVT_MASK: HRDATA[EVT_LATCH_BIT] = evt_mask_r;
        default: HRDATA = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // CPU side outputs
  // ****************************************
  logic unmasked;
  assign unmasked = pending && !mask_r; // R6
  assign EXT_INT_REQ = unmasked && !CPU.global_mask; // R7
  assign WAKEUP = unmasked && (CPU.wait_state || CPU.stop_state); // R15
  assign BRANCH_PIN_HIGH = func_en ? pin_s2_r : 1'b1; // R12
  assign PORT_A_BIT_TWO_RD = func_en ? 1'b0 : PORT_A_BIT_TWO_IN; // R13 R1
  assign PULLUP_EN = !config_two_r[CFG_PULLUP_DIS_BIT]; // R14

  // ****************************************
  // Checks
  // ****************************************
  property p_edge_sets;
    @(posedge MCLK) disable iff (RST) fall_edge |=> latch_r;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set latch"); // R9

  property p_ack_clears;
    @(posedge MCLK) disable iff (RST) (any_ack && !fall_edge) |=> !latch_r;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear"); // R10

  property p_hold;
    @(posedge MCLK) disable iff (RST) (latch_r && !any_ack) |=> latch_r;
  endproperty
  a_hold: assert property (p_hold) else $error("latch dropped"); // R2

  property p_mask;
    @(posedge MCLK) disable iff (RST) mask_r |-> !EXT_INT_REQ;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request shown"); // R6

  property p_gmask;
    @(posedge MCLK) disable iff (RST) CPU.global_mask |-> !EXT_INT_REQ;
  endproperty
  a_gmask: assert property (p_gmask) else $error("global mask ignored"); // R7

  property p_level;
    @(posedge MCLK) disable iff (RST) (mode_r && func_en && !pin_s2_r) |-> pending;
  endproperty
  a_level: assert property (p_level) else $error("level request lost"); // R8

  property p_break;
    @(posedge MCLK) disable iff (RST)
      (CPU.break_state && !clear_en_r && latch_r && !CPU.vector_fetch) |=> latch_r;
  endproperty
  a_break: assert property (p_break) else $error("break cleared latch"); // R17

  property p_disabled;
    @(posedge MCLK) disable iff (RST) !func_en |-> BRANCH_PIN_HIGH && !fall_edge;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled pin seen"); // R12

  property p_edge_detect;
    @(posedge MCLK) disable iff (RST)
      (func_en && $fell(pin_s2_r)) |-> fall_edge;
  endproperty
  a_edge_detect: assert property (p_edge_detect) else $error("edge missed"); // R19

  property p_sync_chain;
    @(posedge MCLK) disable iff (RST) 1'b1 |=> pin_prev_r == $past(pin_s2_r);
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("sync chain broken"); // R19

  property p_port_pass;
    @(posedge MCLK) disable iff (RST) !func_en |-> PORT_A_BIT_TWO_RD == PORT_A_BIT_TWO_IN;
  endproperty
  a_port_pass: assert property (p_port_pass) else $error("port bit not passed"); // R1

  property p_port_zero;
    @(posedge MCLK) disable iff (RST) func_en |-> !PORT_A_BIT_TWO_RD;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("port bit not zero"); // R13

  property p_pullup;
    @(posedge MCLK) disable iff (RST)
      wr_hit(ADDR_CONFIG_TWO) |=> PULLUP_EN == !$past(HWDATA[CFG_PULLUP_DIS_BIT]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup control wrong"); // R14

  property p_vector_clears;
    @(posedge MCLK) disable iff (RST)
      (CPU.vector_fetch && func_en && !fall_edge) |=> !latch_r;
  endproperty
  a_vector_clears: assert property (p_vector_clears) else $error("fetch kept latch"); // R3

  property p_ack_reads_zero;
    @(posedge MCLK) disable iff (RST)
      (rd_pend_r && rd_addr_r == ADDR_STATUS_CONTROL) |-> !HRDATA[SC_ACK_BIT];
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read one"); // R4

  property p_pend_read;
    @(posedge MCLK) disable iff (RST)
      (rd_pend_r && rd_addr_r == ADDR_STATUS_CONTROL) |-> HRDATA[SC_PEND_BIT] == pending;
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("pending flag wrong"); // R11

  property p_wake;
    @(posedge MCLK) disable iff (RST)
      (pending && !mask_r && (CPU.stop_state || CPU.wait_state)) |-> WAKEUP;
  endproperty
  a_wake: assert property (p_wake) else $error("no wakeup"); // R15

  property p_break_clear;
    @(posedge MCLK) disable iff (RST)
      (CPU.break_state && clear_en_r && ack_write && !fall_edge) |=> !latch_r;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break clear ignored"); // R16

  property p_idle_quiet;
    @(posedge MCLK) disable iff (RST) !pending |-> !EXT_INT_REQ && !WAKEUP;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("request without pending"); // R6

  property p_evt_set;
    @(posedge MCLK) disable iff (RST) fall_edge |=> evt_status_r[EVT_LATCH_BIT];
  endproperty
  a_evt_set: assert property (p_evt_set) else $error("event bit not set"); // R9

  property p_mode_write;
    @(posedge MCLK) disable iff (RST)
      wr_hit(ADDR_STATUS_CONTROL) |=> mode_r == $past(HWDATA[SC_MODE_BIT]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode not written"); // R8

endmodule : eipl_top

// File: eipl_pin_model.sv
`timescale 1ns/1ps
module eipl_pin_model (
  // Clock and pullup state
  input wire logic clk,
  input wire logic pullup_en,
  // Line request and line
  input wire logic low_req,
  output logic pin_n
);
  logic last_r;

  always_ff @(posedge clk) begin
    last_r <= pin_n;
  end

  // Without pullup a released line floats, so show a changing level
  assign pin_n = low_req ? 1'b0 : (pullup_en ? 1'b1 : ~last_r);
endmodule : eipl_pin_model

// File: eipl_top_tb.sv
`timescale 1ns/1ps
module eipl_top_tb;
  import eipl_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic [31:0] haddr, HWDATA, HRDATA;
  logic [1:0] htrans;
  logic hwrite, rd_ph, low_req, HREADYOUT, HRESP, EXT_INT_N, PORT_A_BIT_TWO_IN;
  logic EXT_INT_REQ, WAKEUP, BRANCH_PIN_HIGH, PORT_A_BIT_TWO_RD, PULLUP_EN, IRQ;
  eipl_ahb_req_s bus_req;
  eipl_cpu_s cpu;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int checks = 0;
  int seed = 32'hFD91;

  assign bus_req = {haddr, htrans, hwrite, 3'h2, 1'b1, HREADYOUT};
  eipl_top DUT (.MCLK(MCLK), .RST(RST), .AHB_REQ(bus_req), .HWDATA(HWDATA), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_INT_N(EXT_INT_N), .CPU(cpu),
    .PORT_A_BIT_TWO_IN(PORT_A_BIT_TWO_IN), .EXT_INT_REQ(EXT_INT_REQ), .WAKEUP(WAKEUP),
    .BRANCH_PIN_HIGH(BRANCH_PIN_HIGH), .PORT_A_BIT_TWO_RD(PORT_A_BIT_TWO_RD),
    .PULLUP_EN(PULLUP_EN), .IRQ(IRQ));
  eipl_pin_model PIN (.clk(MCLK), .pullup_en(PULLUP_EN), .low_req(low_req), .pin_n(EXT_INT_N));

  initial begin
    forever #4 MCLK = ~MCLK;
  end

  // ****************************************
  // Bus master and checks
  // ****************************************
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge MCLK);
    haddr <= {22'h0, a, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    htrans <= 2'b00;
    HWDATA <= d;
    rd_ph <= ~w;
    do @(posedge MCLK); while (HREADYOUT !== 1'b1);
    rd_ph <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  task automatic chk_rd(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.size() ? exp_q.pop_front() : 32'hX;
    checks++;
    if (got !== e) begin
      n_fail++;
      $display("MISMATCH %0t read %h expected %h", $time, got, e);
    end
  endtask : chk_rd

  task automatic chk_lvl(ref logic got, input logic e);
    @(negedge MCLK);
    checks++;
    if (got !== e) begin
      n_fail++;
      $display("MISMATCH %0t level %b expected %b", $time, got, e);
    end
    @(posedge MCLK);
  endtask : chk_lvl

  task automatic pulse();
    low_req <= 1'b1;
    repeat (3 + ($random(seed) & 3)) @(posedge MCLK);
    low_req <= 1'b0;
    repeat (6) @(posedge MCLK);
  endtask : pulse

  task automatic wrap_up();
    if (n_fail == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge MCLK) begin
    if (rd_ph === 1'b1 && HREADYOUT === 1'b1) chk_rd(HRDATA);
  end

  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {haddr, htrans, hwrite, HWDATA, rd_ph, low_req, PORT_A_BIT_TWO_IN} = '0;
    cpu = '0;
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    PORT_A_BIT_TWO_IN <= 1'($random(seed));
    low_req <= 1'b1;
    repeat (6) @(posedge MCLK);
    chk_lvl(BRANCH_PIN_HIGH, 1'b1);
    chk_lvl(PORT_A_BIT_TWO_RD, PORT_A_BIT_TWO_IN);
    chk_lvl(PULLUP_EN, 1'b1);
    rd(ADDR_CONFIG_TWO, {24'h0, CONFIG_TWO_RST});
    low_req <= 1'b0;
    wr(ADDR_EVT_MASK, 32'h1);
    wr(ADDR_CONFIG_TWO, 32'h2);
    rd(ADDR_STATUS_CONTROL, 32'h0);
    chk_lvl(PORT_A_BIT_TWO_RD, 1'b0);
    pulse();
    rd(ADDR_STATUS_CONTROL, 32'h8);
    chk_lvl(EXT_INT_REQ, 1'b1);
    cpu.global_mask <= 1'b1;
    chk_lvl(EXT_INT_REQ, 1'b0);
    cpu.global_mask <= 1'b0;
    cpu.wait_state <= 1'b1;
    chk_lvl(WAKEUP, 1'b1);
    wr(ADDR_STATUS_CONTROL, 32'h2);
    rd(ADDR_STATUS_CONTROL, 32'hA);
    chk_lvl(EXT_INT_REQ, 1'b0);
    chk_lvl(WAKEUP, 1'b0);
    cpu.wait_state <= 1'b0;
    chk_lvl(IRQ, 1'b1);
    wr(ADDR_STATUS_CONTROL, 32'h4);
    rd(ADDR_STATUS_CONTROL, 32'h0);
    rd(ADDR_EVT_STATUS, 32'h3);
    wr(ADDR_EVT_MASK, 32'h0);
    chk_lvl(IRQ, 1'b0);
    wr(ADDR_EVT_STATUS, 32'h3);
    wr(ADDR_EVT_MASK, 32'h1);
    chk_lvl(IRQ, 1'b0);
    wr(ADDR_STATUS_CONTROL, 32'h1);
    low_req <= 1'b1;
    repeat (6) @(posedge MCLK);
    wr(ADDR_STATUS_CONTROL, 32'h7);
    rd(ADDR_STATUS_CONTROL, 32'hB);
    chk_lvl(EXT_INT_REQ, 1'b0);
    low_req <= 1'b0;
    repeat (6) @(posedge MCLK);
    rd(ADDR_STATUS_CONTROL, 32'h3);
    wr(ADDR_STATUS_CONTROL, 32'h4);
    pulse();
    rd(ADDR_STATUS_CONTROL, 32'h8);
    cpu.vector_fetch <= 1'b1;
    @(posedge MCLK);
    cpu.vector_fetch <= 1'b0;
    rd(ADDR_STATUS_CONTROL, 32'h0);
    pulse();
    cpu.break_state <= 1'b1;
    wr(ADDR_STATUS_CONTROL, 32'h4);
    rd(ADDR_STATUS_CONTROL, 32'h8);
    wr(ADDR_BREAK_FLAG_CONTROL, 32'h80);
    wr(ADDR_STATUS_CONTROL, 32'h4);
    cpu.break_state <= 1'b0;
    rd(ADDR_STATUS_CONTROL, 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    wr(ADDR_STATUS_CONTROL, 32'h1);
    low_req <= 1'b1;
    repeat (6) @(posedge MCLK);
    RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    RST <= 1'b0;
    wr(ADDR_CONFIG_TWO, 32'h2);
    rd(ADDR_STATUS_CONTROL, 32'h0);
    chk_lvl(EXT_INT_REQ, 1'b0);
    low_req <= 1'b0;
    wr(ADDR_CONFIG_TWO, 32'h3);
    chk_lvl(PULLUP_EN, 1'b0);
    rd(ADDR_CONFIG_TWO, 32'h3);
    repeat (3) @(posedge MCLK);
    wrap_up();
  end
endmodule : eipl_top_tb
